// [design/ext_bus_regs.svh]
// Constants for the external bus boot and grant block: offsets, fields, resets
//
// Overview of operation
// - Boot pin high, map pin low: load program memory through the host port first.
// - Boot pin low, map pin low: boot from byte-wide memory on the data bus.
// - Both pins high: ROM on, execution starts at program address 0x0800, no boot.
// - In stand-alone mode the ROM enable bit reads 1 through reset.
// - After either boot, execution starts at internal RAM address 0x0000.
// - Map pin high, boot pin low: no boot, start at external address 0x0000.
// - Data memory uses a 14-bit address and data lines 8 to 23.
// - Each external data access drives data select with write strobe or read strobe.
// - On-chip data RAM holds 2K words from data address 0x3000.
// - Data addresses 0x3800 to 0x3FFF decode to the control registers.
// - External data space splits into three zones, each with its own wait count.
// - Every external data zone resets to 7 wait states.
// - The two compatibility wait fields change no access timing.
// - Request while idle: next cycle float outputs, assert grant, halt.
// - With run-while-granted set, execution stalls only at an external access.
// - Request during an access: grant the cycle after that access ends.
// - Grant may fall between two external accesses of one instruction.
// - Request removed: drop grant, drive outputs again, resume execution.
// - Request handling works always, during booting and during reset.
// - Grant-hang asserts while an external cycle is wanted but the bus is away.
// - After the bus returns, run the pending access, then drop grant-hang.
// - Boot after reset only with map pin low and no bus request pending.
// - Read and write strobes always qualified by exactly one memory select.
// - Boot memory interface resets to 7 wait states, programmable 0 to 7.
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH

// ********************************************************************
// Data memory map and program start addresses
// ********************************************************************
`define DM_EXT_LAST      14'h2FFF
`define DM_RAM_BASE      14'h3000
`define DM_RAM_LAST      14'h37FF
`define DM_CTL_BASE      14'h3800
`define SYS_CTRL_ADDR    14'h3FFE
`define SYS_CFG_ADDR     14'h3FFF
`define PM_ROM_START     14'h0800
`define PM_RESET_START   14'h0000

// ********************************************************************
// system_control fields (wait states and ROM enable)
// ********************************************************************
`define ZONE0_LSB        0
`define ZONE1_LSB        3
`define ZONE2_LSB        6
`define COMPAT3_LSB      9
`define COMPAT4_LSB      12
`define ROM_ON_BIT       15
`define SYS_CTRL_RESET   16'h7FFF

// ********************************************************************
// system_config fields (boot wait, page, program wait, run-while-granted)
// ********************************************************************
`define BOOT_WAIT_LSB    0
`define BOOT_PAGE_LSB    3
`define PM_WAIT_LSB      6
`define GO_MODE_BIT      12
`define SYS_CFG_RESET    16'h01C7

`define BOOT_BYTES_DEF   16'h0060

`endif

// [design/ext_bus_pkg.sv]
// Types shared by the external bus boot and grant block
package ext_bus_pkg;

  // Boot sequencer after reset
  typedef enum logic [1:0] {
    B_HOLD,
    B_EPROM,
    B_HOST,
    B_RUN
  } boot_state_t;

  // External access engine
  typedef enum logic {
    X_IDLE,
    X_ACT
  } xfer_state_t;

endpackage

// [design/pin_sync.sv]
// Three-stage pin synchroniser with an agree-to-change level output
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter logic IDLE_VAL = 1'b1        // Level shown until the pin is known
) (
  input  wire logic clk,                 // Instruction clock
  input  wire logic rst,                 // Synchronous reset, active high
  input  wire logic pinIn,               // Asynchronous pin
  output logic      level                // Filtered level
);

  logic s1Q;
  logic s2Q;
  logic s3Q;
  logic lvlQ;

  // Stages carry no reset so a pin is still followed while reset is held
  always_ff @(posedge clk) begin
    s1Q <= pinIn;
    s2Q <= s1Q;
    s3Q <= s2Q;
  end

  // Change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (s2Q == s3Q) begin
      lvlQ <= s3Q;
    end else if (rst) begin
      lvlQ <= IDLE_VAL;
    end
  end

  assign level = lvlQ;

endmodule // pin_sync

`default_nettype wire

// [design/ext_bus_boot_and_grant.sv]
// Boot selection, data memory decode, memory strobes and bus request/grant
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_regs.svh"

module ext_bus_boot_and_grant #(
  parameter logic [15:0] BOOT_BYTES = `BOOT_BYTES_DEF   // Bytes read in a memory boot
) (
  input  wire logic        clk,               // Instruction clock, 40 MHz
  input  wire logic        rst,               // Synchronous reset, active high
  input  wire logic        bootSourceSelect,  // Strap: 1 host port, 0 boot memory
  input  wire logic        memoryMapSelect,   // Strap: 1 no boot
  input  wire logic        busRequestN,       // Bus request from outside master
  output logic             busGrantN,         // Bus grant, active low
  output logic             grantHangN,        // Grant hang, active low
  output logic [13:0]      extAddr,           // External address
  output logic             extAddrOe,         // Address drive enable
  input  wire logic [23:0] extDataIn,         // External data bus, input side
  output logic [23:0]      extDataOut,        // External data bus, output side
  output logic [23:0]      extDataOe,         // Per-line data drive enable
  output logic             pmSelectN,         // Program memory select
  output logic             dmSelectN,         // Data memory select
  output logic             bootMemSelectN,    // Boot memory select
  output logic             readStrobeN,       // Read strobe / output enable
  output logic             writeStrobeN,      // Write strobe
  output logic             ctrlOe,            // Select and strobe drive enable
  input  wire logic        coreReq,           // Core access request, held to ack
  input  wire logic        coreWrite,         // Core access is a write
  input  wire logic        corePm,            // 1 program space, 0 data space
  input  wire logic [13:0] coreAddr,          // Core address
  input  wire logic [23:0] coreWrData,        // Core write data
  output logic             coreAck,           // Access done, one cycle
  output logic [23:0]      coreRdData,        // Read data, valid with ack
  output logic             coreHalt,          // Execution halted by grant
  output logic             hostBootActive,    // Host port boot in progress
  input  wire logic        hostBootDone,      // Host port boot finished
  output logic             bootByteValid,     // Boot byte read, one cycle
  output logic [7:0]       bootByte,          // Boot byte
  output logic             startValid,        // Execution may begin
  output logic [13:0]      startAddr,         // First fetch address
  output logic             romOn              // ROM enable bit
);

  // ********************************************************************
  // Helpers
  // ********************************************************************

  // External data space lies below the on-chip RAM
  function automatic logic isExtDm(input logic [13:0] a);
    return a <= `DM_EXT_LAST;
  endfunction

  // Wait count for a data access by zone; compat fields never read
  function automatic logic [2:0] zoneWait(input logic [15:0] ctl, input logic [13:0] a);
    unique case (a[13:12])
      2'h0:    return ctl[`ZONE0_LSB +: 3];
      2'h1:    return ctl[`ZONE1_LSB +: 3];
      default: return ctl[`ZONE2_LSB +: 3];
    endcase
  endfunction

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic reqN;
  logic bmodeLvl;
  logic mmapLvl;

  pin_sync #(.IDLE_VAL(1'b1)) reqSync (
    .clk   (clk),
    .rst   (rst),
    .pinIn (busRequestN),
    .level (reqN)
  );
  pin_sync #(.IDLE_VAL(1'b0)) bmodeSync (
    .clk   (clk),
    .rst   (rst),
    .pinIn (bootSourceSelect),
    .level (bmodeLvl)
  );
  pin_sync #(.IDLE_VAL(1'b0)) mmapSync (
    .clk   (clk),
    .rst   (rst),
    .pinIn (memoryMapSelect),
    .level (mmapLvl)
  );

  // ********************************************************************
  // State
  // ********************************************************************
  ext_bus_pkg::boot_state_t bState_q;
  ext_bus_pkg::xfer_state_t xState_q;
  logic [15:0] sysCtrl_q;
  logic [15:0] sysCfg_q;
  logic        strapBmode_q;
  logic        strapMmap_q;
  logic        grant_q;
  logic        hangN_q;
  logic [2:0]  cnt_q;
  logic        curBoot_q;
  logic        curPm_q;
  logic        curWrite_q;
  logic [15:0] bootCnt_q;
  logic [15:0] dmRam [0:2047];
  logic [23:0] rdData_q;
  logic        ack_q;

  // ********************************************************************
  // Decode and request selection
  // ********************************************************************
  wire reqActive = !reqN;
  wire running   = (bState_q == ext_bus_pkg::B_RUN);
  wire goMode    = sysCfg_q[`GO_MODE_BIT];
  wire xIdle     = (xState_q == ext_bus_pkg::X_IDLE);
  wire finish    = (xState_q == ext_bus_pkg::X_ACT) && (cnt_q == 3'h0);
  wire coreExtReq = coreReq && running && !ack_q && (corePm || isExtDm(coreAddr));
  wire coreIntReq = coreReq && running && !ack_q && !corePm && !isExtDm(coreAddr)
                    && !(grant_q && !goMode);
  wire bootWant  = (bState_q == ext_bus_pkg::B_EPROM) && xIdle && !bootByteValid;
  wire extWant   = (bootWant || coreExtReq) && xIdle;
  // Grant wins over a new access; an access in flight finishes first
  wire grantD    = reqActive && (grant_q || xIdle);
  wire start     = extWant && !reqActive && !grant_q;
  wire isRam     = (coreAddr >= `DM_RAM_BASE) && (coreAddr <= `DM_RAM_LAST);
  wire isCtl     = (coreAddr >= `DM_CTL_BASE);
  wire ctrlWr    = coreIntReq && coreWrite && (coreAddr == `SYS_CTRL_ADDR);
  wire cfgWr     = coreIntReq && coreWrite && (coreAddr == `SYS_CFG_ADDR);
  wire [15:0] bootAddr = {sysCfg_q[`BOOT_PAGE_LSB +: 3], bootCnt_q[12:0]};
  wire [2:0]  startWait = bootWant ? sysCfg_q[`BOOT_WAIT_LSB +: 3]
                        : corePm   ? sysCfg_q[`PM_WAIT_LSB +: 3]
                        : zoneWait(sysCtrl_q, coreAddr);
  wire [15:0] ctlRead  = (coreAddr == `SYS_CTRL_ADDR) ? sysCtrl_q
                       : (coreAddr == `SYS_CFG_ADDR)  ? sysCfg_q : 16'h0000;
  wire lastBoot = (bootCnt_q == BOOT_BYTES - 16'h0001);

  // ********************************************************************
  // Control registers and straps
  // ********************************************************************

  // Straps are caught while reset is held; ROM bit follows them through reset
  always_ff @(posedge clk) begin
    if (rst) begin
      strapBmode_q <= bmodeLvl;
      strapMmap_q  <= mmapLvl;
      sysCtrl_q    <= {bmodeLvl && mmapLvl,
                       15'(`SYS_CTRL_RESET)};
      sysCfg_q     <= `SYS_CFG_RESET;
    end else begin
      if (ctrlWr) begin
        sysCtrl_q <= coreWrData[15:0];
      end
      if (cfgWr) begin
        sysCfg_q <= coreWrData[15:0];
      end
    end
  end

  // On-chip data RAM, no reset so it maps to a memory
  always_ff @(posedge clk) begin
    if (coreIntReq && coreWrite && isRam) begin
      dmRam[coreAddr[10:0]] <= coreWrData[15:0];
    end
  end

  // ********************************************************************
  // Bus grant and grant hang
  // ********************************************************************

  // Grant is evaluated in reset too, so an outside master is never locked out
  always_ff @(posedge clk) begin
    grant_q   <= grantD;
    busGrantN <= !grantD;
    ctrlOe    <= !grantD;
    extAddrOe <= !grantD;
    coreHalt  <= grantD && !goMode;
  end

  // Hang set while blocked wins over clear at the access end
  always_ff @(posedge clk) begin
    if (rst) begin
      hangN_q <= 1'b1;
    end else if (extWant && grant_q) begin
      hangN_q <= 1'b0;
    end else if (finish) begin
      hangN_q <= 1'b1;
    end
  end
  assign grantHangN = hangN_q;

  // ********************************************************************
  // External access engine
  // ********************************************************************

  // Select and strobe are launched together so no strobe runs unqualified
  always_ff @(posedge clk) begin
    if (rst) begin
      xState_q       <= ext_bus_pkg::X_IDLE;
      cnt_q          <= 3'h0;
      curBoot_q      <= 1'b0;
      curPm_q        <= 1'b0;
      curWrite_q     <= 1'b0;
      extAddr        <= 14'h0000;
      extDataOut     <= 24'h000000;
      extDataOe      <= 24'h000000;
      pmSelectN      <= 1'b1;
      dmSelectN      <= 1'b1;
      bootMemSelectN <= 1'b1;
      readStrobeN    <= 1'b1;
      writeStrobeN   <= 1'b1;
    end else if (start) begin
      xState_q       <= ext_bus_pkg::X_ACT;
      cnt_q          <= startWait;
      curBoot_q      <= bootWant;
      curPm_q        <= corePm;
      curWrite_q     <= !bootWant && coreWrite;
      extAddr        <= bootWant ? bootAddr[13:0] : coreAddr;
      extDataOut     <= bootWant ? {bootAddr[15:14], 22'h000000}
                      : corePm   ? coreWrData
                      : {coreWrData[15:0], 8'h00};
      extDataOe      <= bootWant ? 24'hC00000
                      : !coreWrite ? 24'h000000
                      : corePm   ? 24'hFFFFFF : 24'hFFFF00;
      pmSelectN      <= !(!bootWant && corePm);
      dmSelectN      <= !(!bootWant && !corePm);
      bootMemSelectN <= !bootWant;
      readStrobeN    <= !(bootWant || !coreWrite);
      writeStrobeN   <= !(!bootWant && coreWrite);
    end else if (finish) begin
      xState_q       <= ext_bus_pkg::X_IDLE;
      extDataOe      <= 24'h000000;
      pmSelectN      <= 1'b1;
      dmSelectN      <= 1'b1;
      bootMemSelectN <= 1'b1;
      readStrobeN    <= 1'b1;
      writeStrobeN   <= 1'b1;
    end else if (xState_q == ext_bus_pkg::X_ACT) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end

  // ********************************************************************
  // Answers to the core
  // ********************************************************************

  // Internal answers take one cycle; external ones come at the access end
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q    <= 1'b0;
      rdData_q <= 24'h000000;
    end else begin
      ack_q <= coreIntReq || (finish && !curBoot_q);
      if (coreIntReq && !coreWrite) begin
        rdData_q <= {8'h00, isRam ? dmRam[coreAddr[10:0]] : isCtl ? ctlRead : 16'h0000};
      end else if (finish && !curBoot_q && !curWrite_q) begin
        rdData_q <= curPm_q ? extDataIn : {8'h00, extDataIn[23:8]};
      end
    end
  end
  assign coreAck    = ack_q;
  assign coreRdData = rdData_q;

  // ********************************************************************
  // Boot sequencer
  // ********************************************************************

  // Waits in hold while a request or grant is pending, then picks the mode
  always_ff @(posedge clk) begin
    if (rst) begin
      bState_q       <= ext_bus_pkg::B_HOLD;
      bootCnt_q      <= 16'h0000;
      bootByteValid  <= 1'b0;
      bootByte       <= 8'h00;
      hostBootActive <= 1'b0;
      startValid     <= 1'b0;
      startAddr      <= `PM_RESET_START;
    end else begin
      bootByteValid <= 1'b0;
      unique case (bState_q)
        ext_bus_pkg::B_HOLD: begin
          if (!reqActive && !grant_q) begin
            if (strapMmap_q) begin
              bState_q   <= ext_bus_pkg::B_RUN;
              startValid <= 1'b1;
              startAddr  <= strapBmode_q ? `PM_ROM_START
                                         : `PM_RESET_START;
            end else if (strapBmode_q) begin
              bState_q       <= ext_bus_pkg::B_HOST;
              hostBootActive <= 1'b1;
            end else begin
              bState_q <= ext_bus_pkg::B_EPROM;
            end
          end
        end
        ext_bus_pkg::B_EPROM: begin
          if (finish && curBoot_q) begin
            bootByteValid <= 1'b1;
            bootByte      <= extDataIn[15:8];
            bootCnt_q     <= bootCnt_q + 16'h0001;
            if (lastBoot) begin
              bState_q   <= ext_bus_pkg::B_RUN;
              startValid <= 1'b1;
              startAddr  <= `PM_RESET_START;
            end
          end
        end
        ext_bus_pkg::B_HOST: begin
          if (hostBootDone) begin
            bState_q       <= ext_bus_pkg::B_RUN;
            hostBootActive <= 1'b0;
            startValid     <= 1'b1;
            startAddr      <= `PM_RESET_START;
          end
        end
        ext_bus_pkg::B_RUN: begin
          startValid <= 1'b1;
        end
      endcase
    end
  end

  // ROM enable is the stored bit
  always_ff @(posedge clk) begin
    romOn <= sysCtrl_q[`ROM_ON_BIT];
  end

endmodule // ext_bus_boot_and_grant

`default_nettype wire

// [tb/ext_bus_checker.sv]
// Concurrent checks on the boot, select and grant ports of the external bus block
`timescale 1ns/1ps
`default_nettype none
module ext_bus_checker (
  input wire logic        clk,            // Clock
  input wire logic        rst,            // Reset
  input wire logic        busRequestN,    // Request pin
  input wire logic        busGrantN,      // Grant
  input wire logic        grantHangN,     // Hang
  input wire logic        extAddrOe,      // Address enable
  input wire logic [23:0] extDataOe,      // Data enables
  input wire logic        pmSelectN,      // PM select
  input wire logic        dmSelectN,      // DM select
  input wire logic        bootMemSelectN, // Boot select
  input wire logic        readStrobeN,    // Read strobe
  input wire logic        writeStrobeN,   // Write strobe
  input wire logic        ctrlOe,         // Select enable
  input wire logic        startValid,     // Start flag
  input wire logic [13:0] startAddr,      // Start address
  input wire logic        romOn           // ROM bit
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Synchroniser plus one longest access bounds the grant; release needs only the synchroniser
  sequence sGrantSoon;
    ##[1:16] !busGrantN;
  endsequence
  sequence sGrantGone;
    ##[1:6] busGrantN;
  endsequence
  wire logic anySel = !pmSelectN || !dmSelectN || !bootMemSelectN;
  AST_ONE_SEL: assert property ($countones({pmSelectN, dmSelectN, bootMemSelectN}) >= 2)
    else $error("two memory selects active");
  AST_STB_QUAL: assert property (!readStrobeN || !writeStrobeN |-> anySel)
    else $error("strobe without select");
  AST_DM_STB: assert property (!dmSelectN && ctrlOe |-> readStrobeN != writeStrobeN)
    else $error("data select without one strobe");
  AST_GRANT_FLOAT: assert property (!busGrantN |-> !ctrlOe && !extAddrOe && extDataOe == 24'h0)
    else $error("outputs driven while granted");
  AST_GRANT_SOON: assert property ($fell(busRequestN) |-> sGrantSoon)
    else $error("grant late");
  AST_GRANT_GONE: assert property ($rose(busRequestN) |-> sGrantGone)
    else $error("grant not released");
  AST_REEN: assert property ($rose(busGrantN) |-> ctrlOe && extAddrOe)
    else $error("drivers not back with grant release");
  AST_HANG_FALL: assert property ($fell(grantHangN) |-> !$past(busGrantN))
    else $error("hang without grant");
  AST_HANG_RISE: assert property ($rose(grantHangN) |-> busGrantN)
    else $error("hang cleared while granted");
  AST_START: assert property ($rose(startValid) |-> startAddr == (romOn ? 14'h0800 : 14'h0000))
    else $error("wrong start address");
endmodule // ext_bus_checker
bind ext_bus_boot_and_grant ext_bus_checker ext_bus_checker_i (.clk, .rst, .busRequestN, .busGrantN,
  .grantHangN, .extAddrOe, .extDataOe, .pmSelectN, .dmSelectN, .bootMemSelectN, .readStrobeN,
  .writeStrobeN, .ctrlOe, .startValid, .startAddr, .romOn);
`default_nettype wire

// [tb/ext_master_model.sv]
// Outside bus master and external memory facing the block
`timescale 1ns/1ps
`default_nettype none
module ext_master_model (
  input  wire logic        clk,          // Clock
  input  wire logic        want,         // Bench asks for the bus
  input  wire logic        grantHangN,   // Hang from the block
  input  wire logic        readStrobeN,  // Read strobe
  input  wire logic        writeStrobeN, // Write strobe
  input  wire logic        dmSelectN,    // DM select
  input  wire logic [13:0] extAddr,      // Address
  input  wire logic [23:0] extDataOut,   // Data from the block
  output logic             busRequestN,  // Request pin
  output logic [23:0]      extDataIn,    // Data to the block
  output logic [15:0]      lastWr        // Last data word written
);
  logic        hung = 1'b0;        // Bus given back after hang, until want drops
  logic [23:0] junk = 24'h5A5A5A;  // Undriven bus pattern
  assign busRequestN = !(want && !hung);
  // Memory answers only under read strobe; otherwise the bus toggles so stale data never looks valid
  assign extDataIn = readStrobeN ? junk : {extAddr[7:0], ~extAddr[7:0], extAddr[7:0]};
  initial lastWr = 16'h0;
  // Release on hang, record data words written
  always @(posedge clk) begin
    junk <= ~junk;
    if (!want)
      hung <= 1'b0;
    else if (!grantHangN)
      hung <= 1'b1;
    if (!writeStrobeN && !dmSelectN)
      lastWr <= extDataOut[23:8];
  end
endmodule // ext_master_model
`default_nettype wire

// [tb/ext_bus_boot_and_grant_tb.sv]
// Self-checking bench for the external bus boot and grant block
`timescale 1ns/1ps
`default_nettype none
module ext_bus_boot_and_grant_tb;
  logic clk = 0, rst = 1, bootSourceSelect = 0, memoryMapSelect = 0, hostBootDone = 0;
  logic coreReq = 0, coreWrite = 0, corePm = 0, want = 0;
  logic [13:0] coreAddr = 14'h0;
  logic [23:0] coreWrData = 24'h0, q;
  wire logic busRequestN, busGrantN, grantHangN, extAddrOe, pmSelectN, dmSelectN, bootMemSelectN;
  wire logic readStrobeN, writeStrobeN, ctrlOe, coreAck, coreHalt, hostBootActive, bootByteValid;
  wire logic startValid, romOn;
  wire logic [13:0] extAddr, startAddr;
  wire logic [23:0] extDataIn, extDataOut, extDataOe, coreRdData;
  wire logic [7:0] bootByte;
  wire logic [15:0] lastWr;
  int fail_count = 0, tests_run = 0, bytes = 0, hosts = 0, hangs = 0, n = 0;
  logic [13:0] za [3] = '{14'h0010, 14'h1010, 14'h2FFF};
  int zw [3] = '{0, 1, 3};
  always #12.5 clk = ~clk;
  ext_bus_boot_and_grant #(.BOOT_BYTES(16'h0004)) ext_bus_boot_and_grant_i (.clk, .rst,
    .bootSourceSelect, .memoryMapSelect, .busRequestN, .busGrantN, .grantHangN, .extAddr, .extAddrOe,
    .extDataIn, .extDataOut, .extDataOe, .pmSelectN, .dmSelectN, .bootMemSelectN, .readStrobeN,
    .writeStrobeN, .ctrlOe, .coreReq, .coreWrite, .corePm, .coreAddr, .coreWrData, .coreAck,
    .coreRdData, .coreHalt, .hostBootActive, .hostBootDone, .bootByteValid, .bootByte, .startValid,
    .startAddr, .romOn);
  ext_master_model ext_master_model_i (.clk, .want, .grantHangN, .readStrobeN, .writeStrobeN,
    .dmSelectN, .extAddr, .extDataOut, .busRequestN, .extDataIn, .lastWr);
  // Tally boot bytes, host-boot cycles and hang cycles; the host port answers a boot at once
  always @(posedge clk) begin
    hostBootDone <= hostBootActive && !hostBootDone;
    if (bootByteValid) bytes <= bytes + 1;
    if (hostBootActive) hosts <= hosts + 1;
    if (!grantHangN) hangs <= hangs + 1;
  end
  task chk(string what, logic [23:0] seen, logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic sel(int k);
    case (k)
      0: return !busGrantN;
      1: return busGrantN;
      default: return startValid;
    endcase
  endfunction
  // Bounded wait; running out counts as a mismatch and closes the run
  task waitOn(int k, int lim);
    for (int i = 0; !sel(k); i++) begin
      if (i == lim) begin
        chk("wait bound", 24'h1, 24'h0);
        conclude;
      end
      @(posedge clk);
      #1;
    end
  endtask
  // One core access; n counts edges from raising the request to the acknowledge
  task acc(logic wr, logic [13:0] a, logic [23:0] d);
    @(posedge clk);
    coreReq <= 1'b1;
    coreWrite <= wr;
    coreAddr <= a;
    coreWrData <= d;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n == 60) begin
        chk("ack bound", 24'h1, 24'h0);
        conclude;
      end
    end while (!coreAck);
    q = coreRdData;
    coreReq <= 1'b0;
  endtask
  initial begin
    // Strap settings; the byte-memory boot runs last with a request held across reset
    for (int i = 3; i >= 0; i--) begin
      bootSourceSelect <= i[0];
      memoryMapSelect <= i[1];
      want <= (i == 0);
      rst <= 1'b1;
      bytes = 0;
      hosts = 0;
      repeat (16) @(posedge clk);
      #1;
      chk("rom bit in reset", romOn, i == 3);
      chk("grant in reset", busGrantN, i != 0);
      @(posedge clk);
      rst <= 1'b0;
      if (i == 0) begin
        repeat (12) @(posedge clk);
        #1;
        chk("boot held off", {startValid, bootMemSelectN}, 24'h1);
        want <= 1'b0;
      end
      waitOn(2, 400);
      // The last boot byte is tallied one edge after the start flag rises
      @(posedge clk);
      #1;
      chk("start address", startAddr, i == 3 ? 24'h800 : 24'h0);
      chk("boot bytes", {bytes[7:0], bootByte}, i == 0 ? 24'h04FC : 24'h0);
      chk("host boot", hosts != 0, i == 1);
    end
    acc(0, 14'h3FFE, 24'h0);
    chk("wait reset", {n[7:0], q[15:0]}, 24'h017FFF);
    acc(0, 14'h3FFF, 24'h0);
    chk("config reset", q[15:0], 24'h01C7);
    // Zones get 0, 1 and 3 waits; compatibility fields set to 7 to prove they are ignored
    acc(1, 14'h3FFE, 24'h00FEC8);
    foreach (za[k]) begin
      acc(0, za[k], 24'h0);
      chk("zone cycles", 24'(n), 24'(zw[k] + 2));
      chk("zone data", q[15:0], {za[k][7:0], ~za[k][7:0]});
    end
    acc(1, 14'h0123, 24'h00ABCD);
    chk("data write lines", lastWr, 24'hABCD);
    acc(1, 14'h3000, 24'h001234);
    acc(1, 14'h37FF, 24'h00BEEF);
    acc(1, 14'h3800, 24'h005555);
    acc(0, 14'h3000, 24'h0);
    chk("ram low", q[15:0], 24'h1234);
    acc(0, 14'h37FF, 24'h0);
    chk("ram high", q[15:0], 24'hBEEF);
    acc(0, 14'h3800, 24'h0);
    chk("reserved", q[15:0], 24'h0);
    // Grant while idle, then an external access that must hang until the master lets go
    want <= 1'b1;
    waitOn(0, 20);
    chk("halted and floated", {coreHalt, ctrlOe, extAddrOe}, 24'h4);
    hangs = 0;
    acc(0, 14'h0010, 24'h0);
    repeat (2) @(posedge clk);
    #1;
    chk("hang then access", {hangs != 0, grantHangN, q[15:0]}, 24'h310EF);
    want <= 1'b0;
    // Request lands mid-way through a seven-wait access, which must finish first
    acc(1, 14'h3FFE, 24'h00FFC8);
    fork
      acc(0, 14'h2000, 24'h0);
      begin
        repeat (4) @(posedge clk);
        want <= 1'b1;
      end
    join
    chk("long access whole", 24'(n), 24'h9);
    waitOn(0, 12);
    want <= 1'b0;
    waitOn(1, 12);
    // Run-while-granted keeps internal register traffic going
    acc(1, 14'h3FFF, 24'h0011C7);
    want <= 1'b1;
    waitOn(0, 20);
    chk("go mode runs", coreHalt, 24'h0);
    acc(0, 14'h3FFE, 24'h0);
    chk("register while granted", {n[7:0], q[15:0]}, 24'h01FFC8);
    want <= 1'b0;
    waitOn(1, 20);
    chk("drivers back", {ctrlOe, extAddrOe}, 24'h3);
    conclude;
  end
endmodule // ext_bus_boot_and_grant_tb
`default_nettype wire
